// ### hw/timer_defs.svh
// register addresses, field positions, reset values and divider counts
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define ADDR_RUN_FLAG_CTRL  8'h88
`define ADDR_MODE_CTRL      8'h89
`define ADDR_ZERO_LOW       8'h8A
`define ADDR_ONE_LOW        8'h8B
`define ADDR_ZERO_HIGH      8'h8C
`define ADDR_ONE_HIGH       8'h8D
`define ADDR_CLOCK_SEL      8'h8E
`define ADDR_IRQ_ENABLE     8'hA8

`define BIT_ONE_OVF         7
`define BIT_ONE_RUN         6
`define BIT_ZERO_OVF        5
`define BIT_ZERO_RUN        4
`define BIT_EXT_ONE_FLAG    3
`define BIT_EXT_ONE_TYPE    2
`define BIT_EXT_ZERO_FLAG   1
`define BIT_EXT_ZERO_TYPE   0

`define FIELD_ONE_BASE      4
`define FIELD_ZERO_BASE     0
`define BIT_MODE_LOW        0
`define BIT_MODE_HIGH       1
`define BIT_COUNT_SEL       2
`define BIT_PIN_GATE        3

`define BIT_ZERO_CLK_SEL    3
`define BIT_ONE_CLK_SEL     4

`define BIT_GLOBAL_EN       7
`define BIT_ONE_TMR_EN      3
`define BIT_EXT_ONE_EN      2
`define BIT_ZERO_TMR_EN     1
`define BIT_EXT_ZERO_EN     0

`define PIN_ZERO_COUNT      0
`define PIN_ONE_COUNT       1
`define PIN_EXT_ZERO        2
`define PIN_EXT_ONE         3

`define RST_RUN_FLAG        8'h00
`define RST_MODE            8'h00
`define RST_COUNT           8'h00
`define RST_CLOCK_SEL       8'h01
`define RST_IRQ_ENABLE      8'h00
`define UNMAPPED_READ       8'hFF

`define PRESCALE_TOP        5'h1F
`define BYTE_TOP            8'hFF
`define DIV_FAST            4
`define DIV_SLOW            12

`endif

// ### hw/timer_pkg.sv
// types shared by the timer/counter block
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_FULL     = 2'b01,
        MODE_RELOAD   = 2'b10,
        MODE_SPLIT    = 2'b11
    } timer_mode_e;

    typedef logic [7:0] byte_t;

endpackage : timer_pkg

// ### hw/pin_sync_edge.sv
// two-flop pin synchroniser with falling-edge detection
module pin_sync_edge #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinLevel,
    output logic      [WIDTH-1:0] pinFall
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // pins idle high, so reset high to avoid a false edge at release
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end
        else
        begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign pinLevel = sync_reg;
    assign pinFall  = prev_reg & ~sync_reg;

endmodule : pin_sync_edge

// ### hw/tick_divider.sv
// free-running divider giving a one-cycle tick every DIV clocks
module tick_divider #(
    parameter int unsigned DIV = 12
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    output logic      tick
);

    localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] TOP = W'(DIV - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign tick     = (cnt_reg == TOP);
    assign cnt_next = tick ? '0 : W'(cnt_reg + 1'b1);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

endmodule : tick_divider

// ### hw/dual_timer_counter.sv
// two timer/counter units with external interrupt detect flags
//
// Overview of operation
// R1 - overflow sets flag; vector clears; software writes
// R2 - unit counts only while run bit set
// R3 - external pin condition sets its detect flag
// R4 - edge flag cleared on vector; level tracks pin
// R5 - type bit selects falling edge or low level
// R6 - gate set: count only with pin high
// R7 - gate clear: count on run bit alone
// R8 - select bit: internal ticks or pin falls
// R9 - mode 00: 8-bit counter, 5-bit prescaler
// R10 - mode 01: 16-bit counter from both bytes
// R11 - mode 10: low byte reloads from high
// R12 - mode 3: unit zero split in two
// R13 - unit one in mode 3 holds value
// R14 - clock select: divide by 4 or 12
// R15 - count bytes readable and writable separately
// R16 - control register bit layout as specified
// R17 - requests gated by own and global enable
// R18 - count and interrupt inputs from port pins
// R19 - mode register: unit one high nibble
// R20 - pins synchronised; modes 0/1 wrap to zero
// R21 - split high byte overflow sets unit one flag
`include "timer_defs.svh"

module dual_timer_counter (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    output logic      [7:0] sfrRdData,
    input  wire logic       unitZeroCountPin,
    input  wire logic       unitOneCountPin,
    input  wire logic       extIntZeroPin,
    input  wire logic       extIntOnePin,
    input  wire logic       unitZeroVectorAck,
    input  wire logic       unitOneVectorAck,
    input  wire logic       extIntZeroVectorAck,
    input  wire logic       extIntOneVectorAck,
    output logic            unitZeroIrqReq,
    output logic            unitOneIrqReq,
    output logic            extIntZeroIrqReq,
    output logic            extIntOneIrqReq
);

    // one counting step: returns {overflow, high, low}
    function automatic logic [16:0] stepCount(
        input logic [1:0]     mode,
        input timer_pkg::byte_t lo,
        input timer_pkg::byte_t hi,
        input logic           inc
    );
        logic [16:0] res;
        res = {1'b0, hi, lo};
        if (inc)
        begin
            unique case (timer_pkg::timer_mode_e'(mode))
                timer_pkg::MODE_PRESCALE:
                begin
                    res[4:0] = 5'(lo[4:0] + 5'h01); // R9
                    if (lo[4:0] == `PRESCALE_TOP)
                    begin
                        res[15:8] = 8'(hi + 8'h01); // R20
                        res[16]   = (hi == `BYTE_TOP);
                    end
                end
                timer_pkg::MODE_FULL:
                begin
                    res[15:0] = 16'({hi, lo} + 16'h0001); // R10
                    res[16]   = ({hi, lo} == {`BYTE_TOP, `BYTE_TOP});
                end
                timer_pkg::MODE_RELOAD:
                begin
                    res[7:0] = (lo == `BYTE_TOP) ? hi : 8'(lo + 8'h01); // R11
                    res[16]  = (lo == `BYTE_TOP);
                end
                timer_pkg::MODE_SPLIT:
                begin
                    res[7:0] = 8'(lo + 8'h01); // R12
                    res[16]  = (lo == `BYTE_TOP);
                end
            endcase
        end
        return res;
    endfunction : stepCount

    timer_pkg::byte_t runFlagControl_reg;
    timer_pkg::byte_t modeControl_reg;
    timer_pkg::byte_t zeroLowByte_reg;
    timer_pkg::byte_t oneLowByte_reg;
    timer_pkg::byte_t zeroHighByte_reg;
    timer_pkg::byte_t oneHighByte_reg;
    timer_pkg::byte_t clockSelect_reg;
    timer_pkg::byte_t irqEnable_reg;
    timer_pkg::byte_t rdData_reg;

    timer_pkg::byte_t runFlagControl_next;
    timer_pkg::byte_t zeroLowByte_next;
    timer_pkg::byte_t oneLowByte_next;
    timer_pkg::byte_t zeroHighByte_next;
    timer_pkg::byte_t oneHighByte_next;
    timer_pkg::byte_t rdData_next;

    logic [3:0] pinLevel;
    logic [3:0] pinFall;
    logic       tickFast;
    logic       tickSlow;

    // port alternate-function inputs, synchronised before use
    pin_sync_edge #(
        .WIDTH (4)
    ) pinSync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .pinIn    ({extIntOnePin, extIntZeroPin, unitOneCountPin, unitZeroCountPin}), // R18
        .pinLevel (pinLevel),
        .pinFall  (pinFall)
    ); // R20

    tick_divider #(
        .DIV (`DIV_FAST)
    ) fastDiv (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .tick    (tickFast)
    );

    tick_divider #(
        .DIV (`DIV_SLOW)
    ) slowDiv (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .tick    (tickSlow)
    );

    // register decode
    logic wrRunFlag;
    logic wrMode;
    logic wrZeroLow;
    logic wrOneLow;
    logic wrZeroHigh;
    logic wrOneHigh;
    logic wrClockSel;
    logic wrIrqEnable;

    assign wrRunFlag   = sfrWrEn && (sfrAddr == `ADDR_RUN_FLAG_CTRL);
    assign wrMode      = sfrWrEn && (sfrAddr == `ADDR_MODE_CTRL);
    assign wrZeroLow   = sfrWrEn && (sfrAddr == `ADDR_ZERO_LOW);
    assign wrOneLow    = sfrWrEn && (sfrAddr == `ADDR_ONE_LOW);
    assign wrZeroHigh  = sfrWrEn && (sfrAddr == `ADDR_ZERO_HIGH);
    assign wrOneHigh   = sfrWrEn && (sfrAddr == `ADDR_ONE_HIGH);
    assign wrClockSel  = sfrWrEn && (sfrAddr == `ADDR_CLOCK_SEL);
    assign wrIrqEnable = sfrWrEn && (sfrAddr == `ADDR_IRQ_ENABLE);

    // control fields
    logic [3:0] zeroModeField;
    logic [3:0] oneModeField;
    logic [1:0] zeroMode;
    logic [1:0] oneMode;
    logic       zeroRun;
    logic       oneRun;
    logic       extZeroEdge;
    logic       extOneEdge;

    assign zeroModeField = modeControl_reg[`FIELD_ZERO_BASE +: 4]; // R19
    assign oneModeField  = modeControl_reg[`FIELD_ONE_BASE +: 4]; // R19
    assign zeroMode = {zeroModeField[`BIT_MODE_HIGH], zeroModeField[`BIT_MODE_LOW]};
    assign oneMode  = {oneModeField[`BIT_MODE_HIGH], oneModeField[`BIT_MODE_LOW]};
    assign zeroRun  = runFlagControl_reg[`BIT_ZERO_RUN];
    assign oneRun   = runFlagControl_reg[`BIT_ONE_RUN];
    assign extZeroEdge = runFlagControl_reg[`BIT_EXT_ZERO_TYPE]; // R5
    assign extOneEdge  = runFlagControl_reg[`BIT_EXT_ONE_TYPE]; // R5

    // internal tick rate per unit
    logic zeroTick;
    logic oneTick;

    assign zeroTick = clockSelect_reg[`BIT_ZERO_CLK_SEL] ? tickFast : tickSlow; // R14
    assign oneTick  = clockSelect_reg[`BIT_ONE_CLK_SEL] ? tickFast : tickSlow; // R14

    // run qualification with optional pin gating
    logic zeroEnable;
    logic oneEnable;

    assign zeroEnable = zeroRun &&
        (!zeroModeField[`BIT_PIN_GATE] || pinLevel[`PIN_EXT_ZERO]); // R2 R6 R7
    assign oneEnable  = oneRun &&
        (!oneModeField[`BIT_PIN_GATE] || pinLevel[`PIN_EXT_ONE]); // R2 R6 R7

    // count source: internal tick or falling edge of count pin
    logic zeroEvent;
    logic oneEvent;

    assign zeroEvent = zeroModeField[`BIT_COUNT_SEL] ? pinFall[`PIN_ZERO_COUNT] : zeroTick; // R8
    assign oneEvent  = oneModeField[`BIT_COUNT_SEL] ? pinFall[`PIN_ONE_COUNT] : oneTick; // R8

    logic zeroInc;
    logic oneInc;
    logic splitHighInc;
    logic zeroSplit;

    assign zeroSplit    = (zeroMode == timer_pkg::MODE_SPLIT);
    assign zeroInc      = zeroEnable && zeroEvent;
    assign oneInc       = oneEnable && oneEvent && (oneMode != timer_pkg::MODE_SPLIT); // R13
    // split high byte is a timer only, run by unit one's run bit
    assign splitHighInc = zeroSplit && oneRun && oneTick; // R12

    logic [16:0] zeroStep;
    logic [16:0] oneStep;
    logic [8:0]  splitHighSum;
    logic        splitHighOvf;

    assign zeroStep = stepCount(zeroMode, zeroLowByte_reg, zeroHighByte_reg, zeroInc);
    assign oneStep  = stepCount(oneMode, oneLowByte_reg, oneHighByte_reg, oneInc);
    assign splitHighSum = {1'b0, zeroHighByte_reg} + 9'h001;
    assign splitHighOvf = splitHighInc && splitHighSum[8]; // R21

    // software writes win over counting for the addressed byte
    logic [7:0] zeroHighCounted;

    assign zeroHighCounted   = zeroSplit ?
        (splitHighInc ? splitHighSum[7:0] : zeroHighByte_reg) : zeroStep[15:8];
    assign zeroLowByte_next  = wrZeroLow ? sfrWrData : zeroStep[7:0]; // R15
    assign zeroHighByte_next = wrZeroHigh ? sfrWrData : zeroHighCounted; // R15
    assign oneLowByte_next   = wrOneLow ? sfrWrData : oneStep[7:0]; // R15
    assign oneHighByte_next  = wrOneHigh ? sfrWrData : oneStep[15:8]; // R15

    // overflow flags: hardware set wins over vector or software clear
    logic zeroOvfSet;
    logic oneOvfSet;
    logic zeroOvfKeep;
    logic oneOvfKeep;

    assign zeroOvfSet  = zeroStep[16];
    assign oneOvfSet   = oneStep[16] || splitHighOvf; // R21
    assign zeroOvfKeep = wrRunFlag ? sfrWrData[`BIT_ZERO_OVF] :
        (runFlagControl_reg[`BIT_ZERO_OVF] && !unitZeroVectorAck); // R1
    assign oneOvfKeep  = wrRunFlag ? sfrWrData[`BIT_ONE_OVF] :
        (runFlagControl_reg[`BIT_ONE_OVF] && !unitOneVectorAck); // R1

    // external detect flags: edge latches, level follows pin
    logic extZeroKeep;
    logic extOneKeep;
    logic extZeroFlag;
    logic extOneFlag;

    assign extZeroKeep = wrRunFlag ? sfrWrData[`BIT_EXT_ZERO_FLAG] :
        (runFlagControl_reg[`BIT_EXT_ZERO_FLAG] && !extIntZeroVectorAck); // R4
    assign extOneKeep  = wrRunFlag ? sfrWrData[`BIT_EXT_ONE_FLAG] :
        (runFlagControl_reg[`BIT_EXT_ONE_FLAG] && !extIntOneVectorAck); // R4
    assign extZeroFlag = extZeroEdge ?
        (extZeroKeep || pinFall[`PIN_EXT_ZERO]) : !pinLevel[`PIN_EXT_ZERO]; // R3 R4
    assign extOneFlag  = extOneEdge ?
        (extOneKeep || pinFall[`PIN_EXT_ONE]) : !pinLevel[`PIN_EXT_ONE]; // R3 R4

    logic [1:0] runBits;

    assign runBits = wrRunFlag ? {sfrWrData[`BIT_ONE_RUN], sfrWrData[`BIT_ZERO_RUN]} :
        {oneRun, zeroRun}; // R2

    assign runFlagControl_next = {
        oneOvfKeep || oneOvfSet,
        runBits[1],
        zeroOvfKeep || zeroOvfSet,
        runBits[0],
        extOneFlag,
        wrRunFlag ? sfrWrData[`BIT_EXT_ONE_TYPE] : extOneEdge,
        extZeroFlag,
        wrRunFlag ? sfrWrData[`BIT_EXT_ZERO_TYPE] : extZeroEdge
    }; // R1 R16

    // read mux; unmapped addresses read high
    assign rdData_next =
        (sfrAddr == `ADDR_RUN_FLAG_CTRL) ? runFlagControl_reg :
        (sfrAddr == `ADDR_MODE_CTRL)     ? modeControl_reg :
        (sfrAddr == `ADDR_ZERO_LOW)      ? zeroLowByte_reg :
        (sfrAddr == `ADDR_ONE_LOW)       ? oneLowByte_reg :
        (sfrAddr == `ADDR_ZERO_HIGH)     ? zeroHighByte_reg :
        (sfrAddr == `ADDR_ONE_HIGH)      ? oneHighByte_reg :
        (sfrAddr == `ADDR_CLOCK_SEL)     ? clockSelect_reg :
        (sfrAddr == `ADDR_IRQ_ENABLE)    ? irqEnable_reg : `UNMAPPED_READ; // R15 R16

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            runFlagControl_reg <= `RST_RUN_FLAG;
            zeroLowByte_reg    <= `RST_COUNT;
            oneLowByte_reg     <= `RST_COUNT;
            zeroHighByte_reg   <= `RST_COUNT;
            oneHighByte_reg    <= `RST_COUNT;
        end
        else
        begin
            runFlagControl_reg <= runFlagControl_next;
            zeroLowByte_reg    <= zeroLowByte_next;
            oneLowByte_reg     <= oneLowByte_next;
            zeroHighByte_reg   <= zeroHighByte_next;
            oneHighByte_reg    <= oneHighByte_next;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            modeControl_reg <= `RST_MODE;
            clockSelect_reg <= `RST_CLOCK_SEL;
            irqEnable_reg   <= `RST_IRQ_ENABLE;
        end
        else
        begin
            if (wrMode)
                modeControl_reg <= sfrWrData;
            if (wrClockSel)
                clockSelect_reg <= sfrWrData;
            if (wrIrqEnable)
                irqEnable_reg <= sfrWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rdData_reg <= `UNMAPPED_READ;
        else if (sfrRdEn)
            rdData_reg <= rdData_next;
    end

    assign sfrRdData = rdData_reg;

    // interrupt requests: own enable and global enable
    logic globalEnable;

    assign globalEnable     = irqEnable_reg[`BIT_GLOBAL_EN];
    assign unitZeroIrqReq   = globalEnable && irqEnable_reg[`BIT_ZERO_TMR_EN] &&
        runFlagControl_reg[`BIT_ZERO_OVF]; // R17
    assign unitOneIrqReq    = globalEnable && irqEnable_reg[`BIT_ONE_TMR_EN] &&
        runFlagControl_reg[`BIT_ONE_OVF]; // R17
    assign extIntZeroIrqReq = globalEnable && irqEnable_reg[`BIT_EXT_ZERO_EN] &&
        runFlagControl_reg[`BIT_EXT_ZERO_FLAG]; // R17
    assign extIntOneIrqReq  = globalEnable && irqEnable_reg[`BIT_EXT_ONE_EN] &&
        runFlagControl_reg[`BIT_EXT_ONE_FLAG]; // R17

endmodule : dual_timer_counter

// ### sim/timer_counter_properties.sv
// concurrent property checker for the dual timer/counter ports
module timer_counter_checker (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic       sfrRdEn,
    input wire logic [7:0] sfrRdData,
    input wire logic       extIntZeroPin,
    input wire logic       extIntZeroVectorAck,
    input wire logic       unitZeroIrqReq,
    input wire logic       unitOneIrqReq,
    input wire logic       extIntZeroIrqReq,
    input wire logic       extIntOneIrqReq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    logic [7:0] enShadow_reg;
    logic       typeZero_reg;
    wire        ctrlWr   = sfrWrEn && (sfrAddr == 8'h88);
    wire        enWr     = sfrWrEn && (sfrAddr == 8'hA8);
    wire        armed    = enShadow_reg[7] && enShadow_reg[0];
    wire        lvlArmed = armed && !typeZero_reg;
    wire        edgArmed = armed && typeZero_reg;
    wire        mapped   = (sfrAddr[7:3] == 5'h11 && sfrAddr != 8'h8F) || sfrAddr == 8'hA8;

    // shadow of the enable and type bits written by software
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            enShadow_reg <= 8'h00;
            typeZero_reg <= 1'b0;
        end
        else
        begin
            enShadow_reg <= enWr ? sfrWrData : enShadow_reg;
            typeZero_reg <= ctrlWr ? sfrWrData[0] : typeZero_reg;
        end
    end

    rst_read_a: assert property ($rose(nrst) |-> sfrRdData == 8'hFF)
        else $error("read data not FF out of reset");
    unmapped_read_a: assert property (sfrRdEn && !mapped |=> sfrRdData == 8'hFF)
        else $error("unmapped read not FF");
    read_hold_a: assert property (!sfrRdEn |=> $stable(sfrRdData))
        else $error("read data moved without a read");
    global_mask_a: assert property (enWr && !sfrWrData[7] |=>
        !(unitZeroIrqReq || unitOneIrqReq || extIntZeroIrqReq || extIntOneIrqReq))
        else $error("request with global enable clear");
    zero_mask_a: assert property (enWr && !sfrWrData[1] |=> !unitZeroIrqReq)
        else $error("unit zero request while disabled");
    level_track_a: assert property ((lvlArmed && !extIntZeroPin) [*4] |-> extIntZeroIrqReq)
        else $error("level flag not following low pin");
    level_clear_a: assert property ((lvlArmed && extIntZeroPin) [*4] |-> !extIntZeroIrqReq)
        else $error("level flag set with pin high");
    edge_set_a: assert property (edgArmed && $fell(extIntZeroPin) |-> ##[1:4] extIntZeroIrqReq)
        else $error("falling edge not flagged");
    edge_ack_a: assert property ((edgArmed && extIntZeroPin) [*4] ##0 extIntZeroVectorAck
        |=> !extIntZeroIrqReq)
        else $error("edge flag not cleared by vector");

    cover property (edgArmed && extIntZeroVectorAck);
    cover property (enWr && sfrWrData[7]);
    cover property (sfrRdEn && !mapped);
endmodule : timer_counter_checker

bind dual_timer_counter timer_counter_checker u_checker (
    .clk_sys, .nrst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn, .sfrRdData,
    .extIntZeroPin, .extIntZeroVectorAck, .unitZeroIrqReq, .unitOneIrqReq,
    .extIntZeroIrqReq, .extIntOneIrqReq
);

// ### sim/ext_pin_model.sv
// model of the port pins feeding the count and interrupt inputs
module ext_pin_model (
    input wire logic       clk_sys,
    output logic     [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins idle high through the port pull-ups
    initial pins = 4'hF;

    task automatic setPin(input int idx, input logic lvl);
        @(posedge clk_sys);
        pins[idx] <= lvl;
    endtask : setPin

    // low then high, each held for width edges at least
    task automatic pulse(input int idx, input int width);
        setPin(idx, 1'b0);
        repeat (width) @(posedge clk_sys);
        setPin(idx, 1'b1);
        repeat (width) @(posedge clk_sys);
    endtask : pulse
endmodule : ext_pin_model

// ### sim/dual_timer_counter_tb_top.sv
// self-checking bench for the dual timer/counter block
module dual_timer_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_sys   = 1'b0;
    logic       nrst      = 1'b0;
    logic [7:0] sfrAddr   = 8'h00;
    logic       sfrWrEn   = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic       sfrRdEn   = 1'b0;
    logic [7:0] sfrRdData;
    logic [3:0] pins;
    logic [3:0] ack       = 4'h0;
    logic [3:0] irq;
    wire  [7:0] irqs      = {4'h0, irq};
    int         errCount  = 0;
    int         checksDone = 0;
    int         cycles    = 0;
    logic [7:0] d;

    always #25 clk_sys = ~clk_sys;

    ext_pin_model u_pins (.clk_sys(clk_sys), .pins(pins));

    dual_timer_counter u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .unitZeroCountPin(pins[0]), .unitOneCountPin(pins[1]),
        .extIntZeroPin(pins[2]), .extIntOnePin(pins[3]),
        .unitZeroVectorAck(ack[1]), .unitOneVectorAck(ack[3]),
        .extIntZeroVectorAck(ack[0]), .extIntOneVectorAck(ack[2]),
        .unitZeroIrqReq(irq[1]), .unitOneIrqReq(irq[3]),
        .extIntZeroIrqReq(irq[0]), .extIntOneIrqReq(irq[2])
    );

    task automatic completeRun();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : completeRun

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errCount++;
            completeRun();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            errCount++;
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfrAddr   <= a;
        sfrWrData <= v;
        sfrWrEn   <= 1'b1;
        @(posedge clk_sys);
        sfrWrEn   <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clk_sys);
        sfrRdEn <= 1'b0;
        @(posedge clk_sys);
        d = sfrRdData;
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(d & m, e);
    endtask : rdChk

    task automatic rngChk(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        rd(a);
        chk((d >= lo && d <= hi) ? lo : d, lo);
    endtask : rngChk

    task automatic ackP(input int idx);
        ack[idx] <= 1'b1;
        @(posedge clk_sys);
        ack[idx] <= 1'b0;
        @(posedge clk_sys);
    endtask : ackP

    task automatic tReset();
        wr(8'h8F, 8'h12);
        for (int a = 8'h88; a < 8'h90; a++)
            rdChk(a[7:0], 8'hFF, a == 8'h8E ? 8'h01 : a == 8'h8F ? 8'hFF : 8'h00);
        rdChk(8'hA8, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++)
            wr(8'h8A + i[7:0], 8'h5A + i[7:0]);
        for (int i = 0; i < 4; i++)
            rdChk(8'h8A + i[7:0], 8'hFF, 8'h5A + i[7:0]);
    endtask : tReset

    task automatic tRates();
        logic [7:0] first;
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h8E, k ? 8'h00 : 8'h08);
            wr(8'h89, 8'h01);
            wr(8'h8A, 8'h00);
            wr(8'h88, 8'h10);
            repeat (k ? 240 : 80) @(posedge clk_sys);
            wr(8'h88, 8'h00);
            rngChk(8'h8A, 8'h13, 8'h16);
            first = d;
            repeat (40) @(posedge clk_sys);
            rdChk(8'h8A, 8'hFF, first);
        end
    endtask : tRates

    task automatic tOverflow();
        wr(8'h8E, 8'h18);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'hFE);
        wr(8'h88, 8'h10);
        repeat (20) @(posedge clk_sys);
        rdChk(8'h88, 8'h20, 8'h20);
        rdChk(8'h8C, 8'hFF, 8'h00);
        wr(8'hA8, 8'h82);
        chk(irqs, 8'h02);
        ackP(1);
        chk(irqs, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h20);
        wr(8'h8D, 8'hF0);
        wr(8'h8B, 8'hFE);
        wr(8'h88, 8'h40);
        repeat (12) @(posedge clk_sys);
        rdChk(8'h88, 8'h80, 8'h80);
        rngChk(8'h8B, 8'hF0, 8'hF5);
        rdChk(8'h8D, 8'hFF, 8'hF0);
        wr(8'hA8, 8'h88);
        chk(irqs, 8'h08);
        ackP(3);
        chk(irqs, 8'h00);
        wr(8'h88, 8'h00);
    endtask : tOverflow

    task automatic tPins();
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'h00);
        wr(8'h89, 8'h04);
        wr(8'h88, 8'h10);
        repeat (3) u_pins.pulse(0, 3);
        rdChk(8'h8A, 8'hFF, 8'hE1);
        rdChk(8'h8C, 8'hFF, 8'h01);
        u_pins.setPin(2, 1'b0);
        repeat (4) @(posedge clk_sys);
        u_pins.pulse(0, 3);
        rdChk(8'h8A, 8'hFF, 8'hE2);
        wr(8'h89, 8'h0C);
        repeat (2) u_pins.pulse(0, 3);
        rdChk(8'h8A, 8'hFF, 8'hE2);
        u_pins.setPin(2, 1'b1);
        repeat (4) @(posedge clk_sys);
        repeat (2) u_pins.pulse(0, 3);
        rdChk(8'h8A, 8'hFF, 8'hE4);
        wr(8'h88, 8'h00);
        wr(8'h8B, 8'h33);
        wr(8'h8A, 8'h00);
        wr(8'h8C, 8'hFF);
        wr(8'h89, 8'h37);
        wr(8'h88, 8'h50);
        repeat (2) u_pins.pulse(0, 3);
        rdChk(8'h8A, 8'hFF, 8'h02);
        rdChk(8'h8B, 8'hFF, 8'h33);
        rdChk(8'h88, 8'h80, 8'h80);
        wr(8'h88, 8'h00);
    endtask : tPins

    task automatic tExt();
        logic [7:0] m;
        for (int i = 0; i < 2; i++)
        begin
            m = 8'h01 << (2 * i);
            wr(8'hA8, 8'h85);
            wr(8'h88, m);
            u_pins.pulse(2 + i, 3);
            chk(irqs & m, m);
            rdChk(8'h88, m << 1, m << 1);
            wr(8'hA8, 8'h05);
            chk(irqs, 8'h00);
            wr(8'hA8, 8'h85);
            ackP(2 * i);
            chk(irqs & m, 8'h00);
            wr(8'h88, 8'h00);
            u_pins.setPin(2 + i, 1'b0);
            repeat (5) @(posedge clk_sys);
            chk(irqs & m, m);
            u_pins.setPin(2 + i, 1'b1);
            repeat (5) @(posedge clk_sys);
            chk(irqs & m, 8'h00);
        end
    endtask : tExt

    initial
    begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        tReset();
        $display("reset and byte access done");
        tRates();
        $display("tick rates done");
        tOverflow();
        $display("overflow and reload done");
        tPins();
        $display("count pin, gate and split done");
        tExt();
        $display("external interrupts done");
        completeRun();
    end
endmodule : dual_timer_counter_tb_top
